// [logic/mcs_commutation_sequencer.sv]
// commutation sequencer: axi4-lite registers, state stepping, synchronized channel outputs
`timescale 1ns/100ps
`include "mcs_regs.svh"
module mcs_commutation_sequencer (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // position source and sensor decoder, same clock
  input  wire logic [15:0] positionCount,
  input  wire logic        linkReq,
  input  wire logic        linkStateValid,
  input  wire logic [3:0]  linkStateNo,
  // outputs
  output logic [7:0]       channelPins,
  output logic             irq
);
  localparam int NCH = `MCS_CHANNELS;
  localparam int NTAB = `MCS_TABLE_DEPTH;
  localparam int SVC_LIMIT = `MCS_SVC_BASE + `MCS_SVC_PER_CH * NCH;

  function automatic logic isTable(input logic [7:0] a);
    return a >= `MCS_A_TABLE && a <= `MCS_A_TABLE_END;
  endfunction

  // register state
  logic [1:0]  seqSel_r, seqSel_nxt;
  logic [15:0] delay_r, delay_nxt, offset_r, offset_nxt;
  logic [15:0] lower_r, lower_nxt, upper_r, upper_nxt, span_r, span_nxt;
  logic [3:0]  lastIdx_r, lastIdx_nxt, stateIdx_r, stateIdx_nxt;
  logic        status_r, status_nxt, mask_r, mask_nxt;
  logic [7:0]  table_r [NTAB];
  logic [7:0]  tableWrData;
  logic [3:0]  tableWrIdx;
  logic        tableWe;
  // bus state
  logic        awHave_r, awHave_nxt, wHave_r, wHave_nxt, bValid_r, bValid_nxt;
  logic [7:0]  awAddr_r, awAddr_nxt;
  logic [31:0] wData_r, wData_nxt, rData_r, rData_nxt;
  logic [3:0]  wStrb_r, wStrb_nxt;
  logic [1:0]  bResp_r, bResp_nxt, rResp_r, rResp_nxt;
  logic        rValid_r, rValid_nxt;
  logic        awRdy_r, wRdy_r, arRdy_r;
  // ready flags registered so every bus output leaves a flip-flop
  wire         awRdyNxt = !awHave_nxt && !bValid_nxt;
  wire         wRdyNxt  = !wHave_nxt && !bValid_nxt;
  wire         arRdyNxt = !rValid_nxt;
  // sequencer state
  mcs_pkg::mcs_state_t st_r, st_nxt;
  logic        modeFlag_r, modeFlag_nxt, matchEn_r, matchEn_nxt, armed_r, armed_nxt;
  logic        pending_r, pending_nxt, updateEv;
  logic [15:0] timebase_r, timebase_nxt, refTime_r, refTime_nxt, adjPos_r, adjPos_nxt;
  logic [15:0] matchTime_r, matchTime_nxt;
  logic [7:0]  pattern_r, pattern_nxt, pins_r, pins_nxt;
  logic        irq_r, irq_nxt;
  logic        hostReq;
  logic [1:0]  hostCode;
  logic        matchHit;

  // write channel: address and data taken in either order, response after both
  always_comb begin
    awHave_nxt = awHave_r;
    wHave_nxt  = wHave_r;
    awAddr_nxt = awAddr_r;
    wData_nxt  = wData_r;
    wStrb_nxt  = wStrb_r;
    bValid_nxt = bValid_r;
    bResp_nxt  = bResp_r;
    if (s_axi_awvalid && !awHave_r && !bValid_r) begin
      awHave_nxt = 1'b1;
      awAddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wHave_r && !bValid_r) begin
      wHave_nxt = 1'b1;
      wData_nxt = s_axi_wdata;
      wStrb_nxt = s_axi_wstrb;
    end
    if (awHave_r && wHave_r) begin
      awHave_nxt = 1'b0;
      wHave_nxt  = 1'b0;
      bValid_nxt = 1'b1;
      bResp_nxt  = (awAddr_r <= `MCS_A_TIMEBASE || isTable(awAddr_r)) ? `MCS_RESP_OKAY : `MCS_RESP_SLVERR;
    end else if (bValid_r && s_axi_bready) begin
      bValid_nxt = 1'b0;
    end
  end

  wire wrGo = awHave_r && wHave_r;
  wire wrB0 = wrGo && wStrb_r[0];
  wire wrB1 = wrGo && wStrb_r[1];

  // read channel
  always_comb begin
    rValid_nxt = rValid_r;
    rData_nxt  = rData_r;
    rResp_nxt  = rResp_r;
    if (s_axi_arvalid && !rValid_r) begin
      rValid_nxt = 1'b1;
      rResp_nxt  = `MCS_RESP_OKAY;
      rData_nxt  = 32'h0000_0000;
      if (isTable(s_axi_araddr)) begin
        rData_nxt[7:0] = table_r[s_axi_araddr[5:2]];
      end else begin
        unique case (s_axi_araddr)
          `MCS_A_CTRL:     rData_nxt[1:0] = seqSel_r;
          `MCS_A_STATUS:   rData_nxt[0] = status_r;
          `MCS_A_MASK:     rData_nxt[0] = mask_r;
          `MCS_A_STATE:    rData_nxt[3:0] = stateIdx_r;
          `MCS_A_DELAY:    rData_nxt[15:0] = delay_r;
          `MCS_A_OFFSET:   rData_nxt[15:0] = offset_r;
          `MCS_A_LOWER:    rData_nxt[15:0] = lower_r;
          `MCS_A_UPPER:    rData_nxt[15:0] = upper_r;
          `MCS_A_SPAN:     rData_nxt[15:0] = span_r;
          `MCS_A_LAST:     rData_nxt[3:0] = lastIdx_r;
          `MCS_A_TIMEBASE: rData_nxt[15:0] = timebase_r;
          default:         rResp_nxt = `MCS_RESP_SLVERR;
        endcase
      end
    end else if (rValid_r && s_axi_rready) begin
      rValid_nxt = 1'b0;
    end
  end

  // host request decode; mode flag has no address
  assign hostCode   = wData_r[`MCS_CTRL_REQ_HI:`MCS_CTRL_REQ_LO];
  assign hostReq    = wrB0 && awAddr_r == `MCS_A_CTRL && hostCode[1];
  assign tableWe    = wrB0 && isTable(awAddr_r);
  assign tableWrIdx = awAddr_r[5:2];
  assign tableWrData = wData_r[7:0];
  assign matchHit   = matchEn_r && timebase_r == matchTime_r;

  // sequencer next state
  always_comb begin
    st_nxt       = st_r;
    modeFlag_nxt = modeFlag_r;
    matchEn_nxt  = matchEn_r;
    armed_nxt    = armed_r;
    pending_nxt  = pending_r;
    refTime_nxt  = refTime_r;
    adjPos_nxt   = adjPos_r;
    stateIdx_nxt = stateIdx_r;
    lower_nxt    = lower_r;
    upper_nxt    = upper_r;
    pattern_nxt  = pattern_r;
    matchTime_nxt = matchTime_r;
    pins_nxt     = pins_r;
    updateEv     = 1'b0;
    timebase_nxt = timebase_r + 16'h0001;
    seqSel_nxt   = seqSel_r;
    offset_nxt   = offset_r;
    span_nxt     = span_r;
    delay_nxt    = delay_r;
    lastIdx_nxt  = lastIdx_r;
    if (wrB0 && awAddr_r == `MCS_A_CTRL) seqSel_nxt = wData_r[1:0];
    if (wrB0 && awAddr_r == `MCS_A_LAST) lastIdx_nxt = wData_r[3:0];
    if (wrB0 && awAddr_r == `MCS_A_DELAY) delay_nxt[7:0] = wData_r[7:0];
    if (wrB1 && awAddr_r == `MCS_A_DELAY) delay_nxt[15:8] = wData_r[15:8];
    if (wrB0 && awAddr_r == `MCS_A_OFFSET) offset_nxt[7:0] = wData_r[7:0];
    if (wrB1 && awAddr_r == `MCS_A_OFFSET) offset_nxt[15:8] = wData_r[15:8];
    if (wrB0 && awAddr_r == `MCS_A_SPAN) span_nxt[7:0] = wData_r[7:0];
    if (wrB1 && awAddr_r == `MCS_A_SPAN) span_nxt[15:8] = wData_r[15:8];
    // applied pattern lands on all pins at the shared match
    if (pending_r && timebase_r == refTime_r) begin
      pins_nxt    = pattern_r;
      pending_nxt = 1'b0;
    end
    if (linkReq && linkStateValid && armed_r) stateIdx_nxt = linkStateNo;
    unique case (st_r)
      mcs_pkg::MCS_IDLE: begin
        if (wrB0 && awAddr_r == `MCS_A_STATE) stateIdx_nxt = wData_r[3:0];
        if (wrB0 && awAddr_r == `MCS_A_LOWER) lower_nxt[7:0] = wData_r[7:0];
        if (wrB1 && awAddr_r == `MCS_A_LOWER) lower_nxt[15:8] = wData_r[15:8];
        if (wrB0 && awAddr_r == `MCS_A_UPPER) upper_nxt[7:0] = wData_r[7:0];
        if (wrB1 && awAddr_r == `MCS_A_UPPER) upper_nxt[15:8] = wData_r[15:8];
        if (hostReq) begin
          armed_nxt   = 1'b1;
          refTime_nxt = timebase_r;
          if (hostCode == `MCS_REQ_FORCE) st_nxt = mcs_pkg::MCS_FORCE;
          else st_nxt = mcs_pkg::MCS_CAPTURE;
        end else if (linkReq && armed_r) begin
          refTime_nxt = timebase_r;
          st_nxt = modeFlag_r ? mcs_pkg::MCS_CAPTURE : mcs_pkg::MCS_FORCE;
        end else if (matchHit) begin
          refTime_nxt = matchTime_r;
          st_nxt = mcs_pkg::MCS_CAPTURE;
        end
      end
      mcs_pkg::MCS_FORCE: begin
        matchEn_nxt  = 1'b0;
        modeFlag_nxt = !seqSel_r[0];
        st_nxt = mcs_pkg::MCS_APPLY;
      end
      mcs_pkg::MCS_CAPTURE: begin
        adjPos_nxt = positionCount + offset_r;
        st_nxt = mcs_pkg::MCS_TEST;
      end
      mcs_pkg::MCS_TEST: begin
        if (adjPos_r < lower_r) begin
          stateIdx_nxt = (stateIdx_r == 4'h0) ? lastIdx_r : stateIdx_r - 4'h1;
          upper_nxt = lower_r;
          lower_nxt = lower_r - span_r;
        end else if (adjPos_r >= upper_r) begin
          stateIdx_nxt = (stateIdx_r >= lastIdx_r) ? 4'h0 : stateIdx_r + 4'h1;
          lower_nxt = upper_r;
          upper_nxt = upper_r + span_r;
        end
        if (!seqSel_r[`MCS_CTRL_SEQ1]) begin
          matchEn_nxt = 1'b1;
        end else begin
          matchEn_nxt  = 1'b0;
          modeFlag_nxt = !seqSel_r[`MCS_CTRL_SEQ0];
        end
        st_nxt = mcs_pkg::MCS_APPLY;
      end
      mcs_pkg::MCS_APPLY: begin
        pattern_nxt   = table_r[stateIdx_r];
        refTime_nxt   = refTime_r + delay_r;
        matchTime_nxt = refTime_r + delay_r;
        pending_nxt   = 1'b1;
        updateEv      = 1'b1;
        st_nxt = mcs_pkg::MCS_IDLE;
      end
    endcase
  end

  // interrupt status, write one to clear, set wins
  always_comb begin
    status_nxt = status_r;
    mask_nxt   = mask_r;
    if (wrB0 && awAddr_r == `MCS_A_STATUS && wData_r[`MCS_ST_UPDATE]) status_nxt = 1'b0;
    if (updateEv) status_nxt = 1'b1;
    if (wrB0 && awAddr_r == `MCS_A_MASK) mask_nxt = wData_r[0];
    irq_nxt = status_nxt && mask_nxt;
  end

  always_ff @(posedge ref_clk) begin
    if (tableWe) table_r[tableWrIdx] <= tableWrData;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      awHave_r <= 1'b0; wHave_r <= 1'b0; bValid_r <= 1'b0; rValid_r <= 1'b0;
      awAddr_r <= 8'h00; wData_r <= 32'h0000_0000; wStrb_r <= 4'h0;
      bResp_r <= `MCS_RESP_OKAY; rResp_r <= `MCS_RESP_OKAY; rData_r <= 32'h0000_0000;
      st_r <= mcs_pkg::MCS_IDLE; modeFlag_r <= 1'b0; matchEn_r <= 1'b0; armed_r <= 1'b0;
      pending_r <= 1'b0; timebase_r <= 16'h0000; refTime_r <= 16'h0000; adjPos_r <= 16'h0000;
      matchTime_r <= 16'h0000; pattern_r <= 8'h00; pins_r <= 8'h00; irq_r <= 1'b0;
      stateIdx_r <= 4'h0; lower_r <= 16'h0000; upper_r <= 16'h0000; span_r <= 16'h0000;
      seqSel_r <= 2'h0; offset_r <= 16'h0000; delay_r <= `MCS_DELAY_RESET;
      lastIdx_r <= `MCS_LAST_RESET; status_r <= 1'b0; mask_r <= 1'b0;
      awRdy_r <= 1'b1; wRdy_r <= 1'b1; arRdy_r <= 1'b1;
    end else begin
      awRdy_r <= awRdyNxt; wRdy_r <= wRdyNxt; arRdy_r <= arRdyNxt;
      awHave_r <= awHave_nxt; wHave_r <= wHave_nxt; bValid_r <= bValid_nxt; rValid_r <= rValid_nxt;
      awAddr_r <= awAddr_nxt; wData_r <= wData_nxt; wStrb_r <= wStrb_nxt;
      bResp_r <= bResp_nxt; rResp_r <= rResp_nxt; rData_r <= rData_nxt;
      st_r <= st_nxt; modeFlag_r <= modeFlag_nxt; matchEn_r <= matchEn_nxt; armed_r <= armed_nxt;
      pending_r <= pending_nxt; timebase_r <= timebase_nxt; refTime_r <= refTime_nxt;
      adjPos_r <= adjPos_nxt; matchTime_r <= matchTime_nxt; pattern_r <= pattern_nxt;
      pins_r <= pins_nxt; irq_r <= irq_nxt;
      stateIdx_r <= stateIdx_nxt; lower_r <= lower_nxt; upper_r <= upper_nxt; span_r <= span_nxt;
      seqSel_r <= seqSel_nxt; offset_r <= offset_nxt; delay_r <= delay_nxt;
      lastIdx_r <= lastIdx_nxt; status_r <= status_nxt; mask_r <= mask_nxt;
    end
  end

  assign s_axi_awready = awRdy_r;
  assign s_axi_wready  = wRdy_r;
  assign s_axi_bvalid  = bValid_r;
  assign s_axi_bresp   = bResp_r;
  assign s_axi_arready = arRdy_r;
  assign s_axi_rvalid  = rValid_r;
  assign s_axi_rdata   = rData_r;
  assign s_axi_rresp   = rResp_r;
  assign channelPins   = pins_r;
  assign irq           = irq_r;
endmodule

// [logic/mcs_regs.svh]
// register map, field positions and timing constants of the commutation sequencer
// Summary of operation
// - force request code 2, or, after the first host request, a link with the mode flag clear, forces output
// - forcing captures the timebase as reference and disables match servicing
// - forcing clears the mode flag if select bit 0 set, else sets it
// - table entry at current state index loads pattern into every channel
// - all channels match together at reference time plus output delay
// - every forced or position update raises an interrupt
// - request code 3, or link with flag set, captures timebase, runs boundary test
// - in match mode a match runs the boundary test using the match time
// - boundary test adds programmed offset to remote position count
// - below lower: index down with wrap to last; boundaries move down one span
// - at or above upper: index up with wrap to zero; boundaries move up
// - select bit 1 clear enables match servicing; set disables and updates flag
// - the internal mode flag is hidden from software
// - service finishes within 34 plus 14 per channel clocks
// - the state table holds 16 entries
`ifndef MCS_REGS_SVH
`define MCS_REGS_SVH
`define MCS_A_CTRL      8'h00
`define MCS_A_STATUS    8'h04
`define MCS_A_MASK      8'h08
`define MCS_A_STATE     8'h0c
`define MCS_A_DELAY     8'h10
`define MCS_A_OFFSET    8'h14
`define MCS_A_LOWER     8'h18
`define MCS_A_UPPER     8'h1c
`define MCS_A_SPAN      8'h20
`define MCS_A_LAST      8'h24
`define MCS_A_TIMEBASE  8'h28
`define MCS_A_TABLE     8'h40
`define MCS_A_TABLE_END 8'h7c
`define MCS_CTRL_SEQ0   0
`define MCS_CTRL_SEQ1   1
`define MCS_CTRL_REQ_LO 4
`define MCS_CTRL_REQ_HI 5
`define MCS_REQ_FORCE   2'h2
`define MCS_REQ_LINK    2'h3
`define MCS_ST_UPDATE   0
`define MCS_SVC_BASE    34
`define MCS_SVC_PER_CH  14
`define MCS_CHANNELS    8
`define MCS_TABLE_DEPTH 16
`define MCS_LAST_RESET  4'h5
`define MCS_DELAY_RESET 16'h0010
`define MCS_RESP_OKAY   2'h0
`define MCS_RESP_SLVERR 2'h2
`endif

// [logic/mcs_pkg.sv]
// types of the commutation sequencer
package mcs_pkg;
  typedef enum logic [2:0] {
    MCS_IDLE,
    MCS_FORCE,
    MCS_CAPTURE,
    MCS_TEST,
    MCS_APPLY
  } mcs_state_t;
endpackage

// [verification/mcs_checker.sv]
// port assertions of the commutation sequencer
`timescale 1ns/100ps
`include "mcs_regs.svh"
module mcs_checker (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  // register bus
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // far side and outputs
  input wire logic        linkReq,
  input wire logic [7:0]  channelPins,
  input wire logic        irq
);
  logic armedR, armedNxt;
  logic maskR,  maskNxt;
  wire  bothTaken = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // shadow of the first host request and of the interrupt mask
  always_comb begin
    armedNxt = armedR | (bothTaken && s_axi_awaddr == `MCS_A_CTRL && s_axi_wdata[5]);
    maskNxt  = (bothTaken && s_axi_awaddr == `MCS_A_MASK) ? s_axi_wdata[0] : maskR;
  end
  always_ff @(posedge ref_clk) begin
    armedR <= sys_rst ? 1'b0 : armedNxt;
    maskR  <= sys_rst ? 1'b0 : maskNxt;
  end
  sequence forceWrite;
    maskR && bothTaken && s_axi_awaddr == `MCS_A_CTRL && s_axi_wdata[5:4] == `MCS_REQ_FORCE;
  endsequence
  sequence irqSoon;
    ##[2:8] irq;
  endsequence
  chk_pins_before_init: assert property (!armedR |-> $stable(channelPins))
    else $error("pins moved before the first request");
  chk_force_irq: assert property (forceWrite |-> irqSoon)
    else $error("no interrupt after a forced update");
  chk_link_bound: assert property (armedR && maskR && linkReq |-> ##[1:146] irq)
    else $error("link service overran its bound");
  chk_irq_masked: assert property ($rose(irq) |-> maskR)
    else $error("interrupt rose while masked");
  chk_b_answer: assert property (bothTaken |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  chk_w_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
endmodule

// [verification/mcs_far_end.sv]
// sensor decoder and position source model
`timescale 1ns/100ps
module mcs_far_end (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  // bench control
  input wire logic [3:0]  evtState,
  input wire logic        evtCarry,
  input wire logic [15:0] posIn,
  // to the sequencer
  output logic [15:0]     positionCount,
  output logic            linkReq,
  output logic            linkStateValid,
  output logic [3:0]      linkStateNo
);
  logic [3:0] prevR;
  assign positionCount = posIn;
  // one link per transition; state lines scrambled between links
  always_ff @(posedge ref_clk) begin
    prevR          <= evtState;
    linkReq        <= !sys_rst && evtState != prevR;
    linkStateValid <= !sys_rst && evtState != prevR && evtCarry;
    linkStateNo    <= (evtState != prevR) ? evtState : ~linkStateNo;
  end
endmodule

// [verification/tb.sv]
// self-checking bench of the commutation sequencer
`timescale 1ns/100ps
`include "mcs_regs.svh"
bind mcs_commutation_sequencer mcs_checker chk_u (.ref_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .linkReq, .channelPins, .irq);
module tb;
  logic        ref_clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        linkReq, linkStateValid, evtCarry, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, channelPins;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [3:0]  s_axi_wstrb, linkStateNo, evtState, s;
  logic [15:0] positionCount, posIn;
  logic [7:0]  tbl[16];
  int          numErrors, nTests, idx, lo, up, off, seed, i, r, adj, c;
  int          pat[7] = '{0, 0, 0, 0, 1, 1, 2};
  mcs_commutation_sequencer dut_u (.ref_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .positionCount,
    .linkReq, .linkStateValid, .linkStateNo, .channelPins, .irq);
  mcs_far_end far_u (.ref_clk, .sys_rst, .evtState, .evtCarry, .posIn, .positionCount, .linkReq, .linkStateValid,
    .linkStateNo);
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      numErrors++;
      $display("unexpected at %0t: value %h, wanted %h", $time, seen, exp);
    end
  endtask
  task testDone;
    $display("errors %0d, checks %0d", numErrors, nTests);
    if (numErrors == 0 && nTests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task axW(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge ref_clk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    for (int k = 0; k < 40; k++) begin
      #1;
      {aw, w, b, resp} = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_bvalid, s_axi_bresp};
      @(posedge ref_clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) break;
    end
    s_axi_bready <= 1'b0;
    if (!b) begin numErrors++; testDone(); end
  endtask
  task axR(input logic [7:0] a);
    logic ar, b;
    @(posedge ref_clk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    for (int k = 0; k < 40; k++) begin
      #1;
      {ar, b, rd, resp} = {s_axi_arvalid & s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      @(posedge ref_clk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (b) break;
    end
    s_axi_rready <= 1'b0;
    if (!b) begin numErrors++; testDone(); end
  endtask
  // one update by host request or link; model index already stepped
  task svc(input logic [31:0] ctrl, input logic link, input logic carry, input logic [3:0] st);
    logic [7:0] was;
    was = channelPins;
    if (link) @(posedge ref_clk) {evtState, evtCarry} <= {st, carry};
    else axW(`MCS_A_CTRL, ctrl);
    for (c = 0; c < 160 && irq !== 1'b1; c++) @(posedge ref_clk) #1;
    check(c <= 146, 1'b1);
    check(channelPins, was);
    for (; c < 90 && channelPins !== tbl[idx]; c++) @(posedge ref_clk) #1;
    if (was !== tbl[idx]) check(c >= 58 && c <= 76, 1'b1);
    check(channelPins, tbl[idx]);
    axW(`MCS_A_STATUS, 32'h1);
    repeat (2) @(posedge ref_clk);
    check(irq, 1'b0);
  endtask
  initial begin
    seed = 32'hdb439004;
    {sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'b100000;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0, 32'h0, 4'hf};
    {evtState, evtCarry, posIn} = 21'h0;
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    axR(`MCS_A_DELAY);
    check(rd, `MCS_DELAY_RESET);
    axR(`MCS_A_LAST);
    check(rd, `MCS_LAST_RESET);
    axR(8'h2c);
    check(resp, `MCS_RESP_SLVERR);
    axW(8'h2c, 32'h1);
    check(resp, `MCS_RESP_SLVERR);
    axW(`MCS_A_MASK, 32'h1);
    @(posedge ref_clk) {evtState, evtCarry} <= 5'h11;
    repeat (100) @(posedge ref_clk);
    check({irq, channelPins}, 9'h0);
    for (i = 0; i < 16; i++) begin
      tbl[i] = {4'($random(seed)), 4'(i)};
      axW(`MCS_A_TABLE + 8'(4 * i), {24'h0, tbl[i]});
    end
    axW(`MCS_A_DELAY, 32'h40);
    axW(`MCS_A_STATE, 32'h3);
    idx = 3;
    svc(32'h20, 1'b0, 1'b0, 4'h0);
    {lo, up, off} = {32'h8000, 32'h9000, $random(seed) & 32'hfff};
    axW(`MCS_A_OFFSET, off);
    axW(`MCS_A_LOWER, lo);
    axW(`MCS_A_UPPER, up);
    axW(`MCS_A_SPAN, 32'h1000);
    for (i = 0; i < 7; i++) begin
      r = $random(seed) & 32'hff;
      if (pat[i] == 0) begin
        {adj, idx, up, lo} = {lo - 1 - r, (idx == 0) ? 5 : idx - 1, lo, lo - 32'h1000};
      end else if (pat[i] == 1) begin
        {adj, idx, lo, up} = {up + ((i == 4) ? 0 : r), (idx == 5) ? 0 : idx + 1, up, up + 32'h1000};
      end else adj = lo + r;
      posIn <= 16'(adj - off);
      svc(32'h32, i[0], 1'b0, evtState + 4'h1);
      axR(`MCS_A_STATE);
      check(rd, idx);
      axR(`MCS_A_LOWER);
      check(rd, lo);
      axR(`MCS_A_UPPER);
      check(rd, up);
    end
    svc(32'h21, 1'b0, 1'b0, 4'h0);
    for (i = 0; i < 3; i++) begin
      s = evtState + 4'h1 + 4'($unsigned($random(seed)) % 14);
      idx = s;
      svc(32'h0, 1'b1, 1'b1, s);
    end
    posIn <= 16'(lo + 5 - off);
    svc(32'h30, 1'b0, 1'b0, 4'h0);
    for (c = 0; c < 120 && irq !== 1'b1; c++) @(posedge ref_clk) #1;
    check(irq, 1'b1);
    axR(`MCS_A_STATE);
    check(rd, idx);
    testDone();
  end
endmodule
